//--- rtl/tcmio_pkg.sv
// tcmio package: register map, field layout, codes and reset values
package tcmio_pkg;

  // ---------------------------------------------------------------
  // register map (index times four is the byte address)
  // ---------------------------------------------------------------
  localparam int AW = 20;
  localparam logic [15:0] MODE_IDX = 16'hFFD1;
  localparam logic [15:0] IOH_IDX  = 16'hFFD2;
  localparam logic [15:0] IOL_IDX  = 16'hFFD3;
  localparam logic [AW-1:0] MODE_ADDR = {2'h0, MODE_IDX, 2'h0};
  localparam logic [AW-1:0] IOH_ADDR  = {2'h0, IOH_IDX, 2'h0};
  localparam logic [AW-1:0] IOL_ADDR  = {2'h0, IOL_IDX, 2'h0};
  localparam logic [AW-1:0] GR_BASE   = 20'h3FF80;
  localparam logic [AW-1:0] STAT_ADDR = 20'h3FF90;

  // ---------------------------------------------------------------
  // fields and reset values
  // ---------------------------------------------------------------
  localparam int MODE_TOP = 3;
  localparam int MODE_PH  = 2;
  localparam int BUF_A    = 4;
  localparam int BUF_B    = 5;
  localparam logic [5:0]  MODE_RST = 6'h00;
  localparam logic [1:0]  MODE_RSV = 2'h3;
  localparam logic [7:0]  IOC_RST  = 8'h00;
  localparam logic [15:0] GR_RST   = 16'hFFFF;
  localparam int CB_CAP  = 3;
  localparam int CB_INIT = 2;

  // ---------------------------------------------------------------
  // codes
  // ---------------------------------------------------------------
  localparam logic [1:0] OC_OFF  = 2'h0;
  localparam logic [1:0] OC_LOW  = 2'h1;
  localparam logic [1:0] OC_HIGH = 2'h2;
  localparam logic [1:0] OC_TGL  = 2'h3;
  localparam logic [1:0] IC_RISE = 2'h0;
  localparam logic [1:0] IC_FALL = 2'h1;
  localparam logic [3:0] MC_NORMAL = 4'h0;
  localparam logic [3:0] MC_PWM1   = 4'h2;
  localparam logic [3:0] MC_PWM2   = 4'h3;

  typedef enum logic [2:0] {
    MD_NORMAL, MD_PWM1, MD_PWM2, MD_PH1, MD_PH2, MD_PH3, MD_PH4, MD_NONE
  } tcmio_mode_t;

endpackage : tcmio_pkg

//--- rtl/tcmio_sync.sv
// tcmio_sync: two-stage synchroniser for one pin level
`timescale 1ns/1ps
module tcmio_sync (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic ce,
  input  wire logic d,
  output logic      q
);
  import tcmio_pkg::*;

  typedef struct packed {
    logic s1;
    logic s2;
  } tcmio_sync_t;

  tcmio_sync_t st_q;
  tcmio_sync_t st_d;

  always_comb begin
    st_d    = st_q;
    st_d.s1 = d;
    st_d.s2 = st_q.s1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
    end else if (ce) begin
      st_q <= st_d;
    end
  end

  assign q = st_q.s2;

endmodule : tcmio_sync

//--- rtl/tcmio_chan.sv
// tcmio_chan: compare output and capture detect for one general register
`timescale 1ns/1ps
module tcmio_chan #(
  parameter int W = 16
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         ce,
  input  wire logic [3:0]   code,
  input  wire logic         inhibit,
  input  wire logic [W-1:0] counter,
  input  wire logic [W-1:0] greg,
  input  wire logic         pin_lvl,
  output logic              cap_p,
  output logic              match_p,
  output logic              pin_out,
  output logic              pin_oe
);
  import tcmio_pkg::*;

  typedef struct packed {
    logic       pin_prev;
    logic       eq_prev;
    logic [3:0] code_prev;
    logic       cap;
    logic       match;
    logic       pout;
    logic       poe;
  } tcmio_chan_t;

  tcmio_chan_t st_q;
  tcmio_chan_t st_d;
  logic        eq;
  logic        rise;
  logic        fall;
  logic        oc;

  assign eq   = (counter == greg);
  assign rise = pin_lvl & ~st_q.pin_prev;
  assign fall = ~pin_lvl & st_q.pin_prev;
  assign oc   = ~inhibit & ~code[CB_CAP];

  always_comb begin
    st_d           = st_q;
    st_d.cap       = 1'b0;
    st_d.match     = 1'b0;
    st_d.pin_prev  = pin_lvl;
    st_d.eq_prev   = eq;
    st_d.code_prev = code;
    // capture only with bit 2 clear
    if (~inhibit && code[CB_CAP] && ~code[CB_INIT]) begin
      if (code[1:0] == IC_RISE) begin
        st_d.cap = rise;
      end else if (code[1:0] == IC_FALL) begin
        st_d.cap = fall;
      end else begin
        st_d.cap = rise | fall;
      end
    end
    st_d.poe = oc && (code[1:0] != OC_OFF);
    if (code != st_q.code_prev) begin
      st_d.pout = code[CB_INIT];
    end else if (oc && eq && ~st_q.eq_prev) begin
      st_d.match = 1'b1;
      unique case (code[1:0])
        OC_OFF:  st_d.pout = st_q.pout;
        OC_LOW:  st_d.pout = 1'b0;
        OC_HIGH: st_d.pout = 1'b1;
        OC_TGL:  st_d.pout = ~st_q.pout;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
    end else if (ce) begin
      st_q <= st_d;
    end
  end

  assign cap_p   = st_q.cap;
  assign match_p = st_q.match;
  assign pin_out = st_q.pout;
  assign pin_oe  = st_q.poe;

endmodule : tcmio_chan

//--- rtl/tcmio_top.sv
// tcmio_top: channel 0 mode, buffer and I/O control with APB access
//
// Implementation choice: the APB register port.
`timescale 1ns/1ps
module tcmio_top #(
  parameter int          W        = 16,
  parameter logic        PHASE_OK = 1'b0
) (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               ce,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [19:0]        paddr,
  input  wire logic [31:0]        pwdata,
  input  wire logic [3:0]         pstrb,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic [W-1:0]       channel_counter,
  input  wire logic [3:0]         ch0_pin_i,
  output logic      [3:0]         ch0_pin_o,
  output logic      [3:0]         ch0_pin_oe,
  output logic      [3:0]         cap_evt,
  output logic      [3:0]         match_evt,
  output tcmio_pkg::tcmio_mode_t  mode_sel,
  output logic                    buffer_pair_ac_select,
  output logic                    buffer_pair_bd_select
);
  import tcmio_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [5:0]          mode;
    logic [7:0]          ioh;
    logic [7:0]          iol;
    logic [3:0][W-1:0]   gr;
    logic [31:0]         prdata;
    logic                pready;
    logic                pslverr;
    tcmio_mode_t         msel;
  } tcmio_top_t;

  tcmio_top_t q;
  tcmio_top_t n;

  logic [3:0] pin_lvl;
  logic [3:0] code [4];
  logic [3:0] inhibit;
  logic       setup;
  logic       acc;
  logic       hit_mode;
  logic       hit_ioh;
  logic       hit_iol;
  logic       hit_gr;
  logic       hit_stat;
  logic [1:0] gidx;

  function automatic tcmio_mode_t mode_decode(input logic [3:0] m);
    tcmio_mode_t r;
    r = MD_NONE;
    // top bit set selects no mode
    if (m[MODE_TOP]) begin
      r = MD_NONE;
    end else if (m[MODE_PH]) begin
      // phase codes void on this channel unless PHASE_OK is set
      if (PHASE_OK) begin
        unique case (m[1:0])
          2'h0: r = MD_PH1;
          2'h1: r = MD_PH2;
          2'h2: r = MD_PH3;
          2'h3: r = MD_PH4;
        endcase
      end
    end else if (m == MC_NORMAL) begin
      r = MD_NORMAL;
    end else if (m == MC_PWM1) begin
      r = MD_PWM1;
    end else if (m == MC_PWM2) begin
      r = MD_PWM2;
    end
    return r;
  endfunction : mode_decode

  // ---------------------------------------------------------------
  // pin synchronisers and per-register logic
  // ---------------------------------------------------------------
  // A from high low nibble, B from high upper nibble
  assign code[0] = q.ioh[3:0];
  assign code[1] = q.ioh[7:4];
  // C from low low nibble, D from low upper nibble
  assign code[2] = q.iol[3:0];
  assign code[3] = q.iol[7:4];
  assign inhibit[2] = q.mode[BUF_A];
  assign inhibit[3] = q.mode[BUF_B];
  assign inhibit[1:0] = 2'h0;

  for (genvar i = 0; i < 4; i++) begin : g_ch
    tcmio_sync u_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .ce      (ce),
      .d       (ch0_pin_i[i]),
      .q       (pin_lvl[i])
    );
    tcmio_chan #(.W(W)) u_chan (
      .pclk    (pclk),
      .presetn (presetn),
      .ce      (ce),
      .code    (code[i]),
      .inhibit (inhibit[i]),
      .counter (channel_counter),
      .greg    (q.gr[i]),
      .pin_lvl (pin_lvl[i]),
      .cap_p   (cap_evt[i]),
      .match_p (match_evt[i]),
      .pin_out (ch0_pin_o[i]),
      .pin_oe  (ch0_pin_oe[i])
    );
  end

  // ---------------------------------------------------------------
  // APB decode
  // ---------------------------------------------------------------
  assign setup    = psel & ~penable;
  assign acc      = psel & penable & q.pready;
  assign hit_mode = (paddr == MODE_ADDR);
  assign hit_ioh  = (paddr == IOH_ADDR);
  assign hit_iol  = (paddr == IOL_ADDR);
  assign hit_gr   = (paddr[19:4] == GR_BASE[19:4]) && (paddr[1:0] == 2'h0);
  assign hit_stat = (paddr == STAT_ADDR);
  assign gidx     = paddr[3:2];

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    n      = q;
    n.msel = mode_decode(q.mode[3:0]);
    if (setup) begin
      n.pready  = 1'b1;
      n.pslverr = 1'b0;
      n.prdata  = 32'h0000_0000;
      if (hit_mode) begin
        n.prdata[7:0] = {MODE_RSV, q.mode};
      end else if (hit_ioh) begin
        n.prdata[7:0] = q.ioh;
      end else if (hit_iol) begin
        n.prdata[7:0] = q.iol;
      end else if (hit_gr) begin
        n.prdata[W-1:0] = q.gr[gidx];
      end else if (hit_stat) begin
        n.prdata[11:0] = {pin_lvl, ch0_pin_oe, ch0_pin_o};
      end else begin
        n.pslverr = 1'b1;
      end
    end
    if (acc) begin
      n.pready  = 1'b0;
      n.pslverr = 1'b0;
      if (pwrite && !q.pslverr) begin
        if (hit_mode && pstrb[0]) begin
          n.mode = pwdata[5:0];
        end
        if (hit_ioh && pstrb[0]) begin
          n.ioh = pwdata[7:0];
        end
        if (hit_iol && pstrb[0]) begin
          n.iol = pwdata[7:0];
        end
        if (hit_gr && pstrb[0]) begin
          n.gr[gidx][7:0] = pwdata[7:0];
        end
        if (hit_gr && pstrb[1]) begin
          n.gr[gidx][15:8] = pwdata[15:8];
        end
      end
    end
    // hardware updates win over a same-cycle software write
    for (int i = 0; i < 2; i++) begin
      if (cap_evt[i]) begin
        // paired capture pushes old value to buffer
        if (q.mode[BUF_A + i]) begin
          n.gr[i + 2] = q.gr[i];
        end
        n.gr[i] = channel_counter;
      end else if (match_evt[i] && q.mode[BUF_A + i]) begin
        n.gr[i] = q.gr[i + 2];
      end
      if (cap_evt[i + 2]) begin
        n.gr[i + 2] = channel_counter;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q.mode    <= MODE_RST;
      q.ioh     <= IOC_RST;
      q.iol     <= IOC_RST;
      q.gr      <= {4{GR_RST}};
      q.prdata  <= 32'h0000_0000;
      q.pready  <= 1'b0;
      q.pslverr <= 1'b0;
      q.msel    <= MD_NORMAL;
    end else if (ce) begin
      q <= n;
    end
  end

  assign prdata                = q.prdata;
  assign pready                = q.pready;
  assign pslverr               = q.pslverr;
  assign mode_sel              = q.msel;
  assign buffer_pair_ac_select = q.mode[BUF_A];
  assign buffer_pair_bd_select = q.mode[BUF_B];

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_mode_pwm: assert property (
    ce && q.mode[3:0] == MC_PWM2 |=> mode_sel == MD_PWM2)
    else $error("pwm2 code not decoded");
  a_mode_top: assert property (
    ce && q.mode[MODE_TOP] |=> mode_sel == MD_NONE)
    else $error("top mode bit not void");
  a_mode_phase: assert property (
    ce && !PHASE_OK && q.mode[MODE_PH] |=> mode_sel == MD_NONE)
    else $error("phase mode taken on channel");
  a_mode_norm: assert property (
    ce && q.mode[3:0] == MC_NORMAL |=> mode_sel == MD_NORMAL)
    else $error("normal mode not decoded");
  a_buf_ac: assert property (
    ce && q.mode[BUF_A] && cap_evt[0] |=> q.gr[2] == $past(q.gr[0]))
    else $error("A capture did not move old value to C");
  a_buf_bd: assert property (
    ce && q.mode[BUF_B] && match_evt[1] && !cap_evt[1]
    |=> q.gr[1] == $past(q.gr[3]))
    else $error("B compare did not reload from D");
  a_ioh_wr: assert property (
    ce && acc && pwrite && hit_ioh && pstrb[0]
    |=> q.ioh == $past(pwdata[7:0]))
    else $error("high control write lost");
  a_iol_wr: assert property (
    ce && acc && pwrite && hit_iol && pstrb[0]
    |=> q.iol == $past(pwdata[7:0]))
    else $error("low control write lost");
  a_oc_off: assert property (
    ce && !code[0][CB_CAP] && code[0][1:0] == OC_OFF |=> !ch0_pin_oe[0])
    else $error("disabled output still enabled");
  a_oc_high: assert property (
    match_evt[0] && $past(ce) && $past(code[0][1:0]) == OC_HIGH
    |-> ch0_pin_o[0])
    else $error("match did not drive high");
  a_oc_tgl: assert property (
    match_evt[0] && $past(ce) && $past(code[0][1:0]) == OC_TGL
    |-> ch0_pin_o[0] != $past(ch0_pin_o[0]))
    else $error("match did not toggle");
  a_ic_rise: assert property (
    ce && $past(ce) && code[0] == 4'h8 && $rose(pin_lvl[0]) |=> cap_evt[0])
    else $error("rising edge not captured");
  a_ic_fall: assert property (
    ce && $past(ce) && code[1] == 4'h9 && $fell(pin_lvl[1]) |=> cap_evt[1])
    else $error("falling edge not captured");
  a_ic_both: assert property (
    ce && $past(ce) && code[0][3:1] == 3'h5 && $changed(pin_lvl[0])
    |=> cap_evt[0])
    else $error("edge not captured in both-edge mode");
  a_c_buffer: assert property (
    ce && q.mode[BUF_A] |=> !cap_evt[2] && !match_evt[2])
    else $error("buffered C produced an event");
  a_d_buffer: assert property (
    ce && q.mode[BUF_B] |=> !cap_evt[3] && !match_evt[3])
    else $error("buffered D produced an event");
  a_cap_copy: assert property (
    ce && cap_evt[1] |=> q.gr[1] == $past(channel_counter))
    else $error("capture did not copy counter");
  a_cap_copy_a: assert property (
    ce && cap_evt[0] |=> q.gr[0] == $past(channel_counter))
    else $error("capture did not copy counter into A");
  a_mode_pwm1: assert property (
    ce && q.mode[3:0] == MC_PWM1 |=> mode_sel == MD_PWM1)
    else $error("pwm1 code not decoded");
  a_oc_init: assert property (
    ce && $past(ce) && $changed(code[0])
    |=> ch0_pin_o[0] == $past(code[0][CB_INIT]))
    else $error("code change did not load initial level");
  a_oc_low: assert property (
    match_evt[0] && $past(ce) && $past(code[0][1:0]) == OC_LOW
    |-> !ch0_pin_o[0])
    else $error("match did not drive low");
  a_ic_prohib: assert property (
    ce && code[0][3:2] == 2'h3 |=> !cap_evt[0] && !ch0_pin_oe[0])
    else $error("prohibited code made an event or output");
  a_ioh_rd: assert property (
    ce && setup && hit_ioh
    |=> prdata == {24'h00_0000, $past(q.ioh)})
    else $error("high control read data wrong");
  a_iol_rd: assert property (
    ce && setup && hit_iol
    |=> prdata == {24'h00_0000, $past(q.iol)})
    else $error("low control read data wrong");

  // ---------------------------------------------------------------
  // covers
  // ---------------------------------------------------------------
  c_cap_a:   cover property (ce && cap_evt[0]);
  c_tgl_b:   cover property (match_evt[1] && code[1][1:0] == OC_TGL);
  c_buf_ld:  cover property (q.mode[BUF_A] && match_evt[0]);
  c_apb_rd:  cover property (acc && !pwrite && hit_ioh);
  c_reload_b: cover property (q.mode[BUF_B] && match_evt[1]);

endmodule : tcmio_top

//--- tb/tcmio_pin_model.sv
// tcmio_pin_model: outside drivers on the four channel 0 timer pins
`timescale 1ns/1ps
module tcmio_pin_model (
  input  wire logic [3:0] pin_o,
  input  wire logic [3:0] pin_oe,
  input  wire logic [3:0] ext_drv,
  output logic      [3:0] pin_i
);
  // ---------------------------------------------------------------
  // wire level
  // ---------------------------------------------------------------
  // block drives the pin while enabled
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      pin_i[i] = pin_oe[i] ? pin_o[i] : ext_drv[i];
    end
  end
endmodule : tcmio_pin_model

//--- tb/tb_timer_ch0_mode_io_control.sv
// tb_timer_ch0_mode_io_control: self-checking bench for tcmio_top
`timescale 1ns/1ps
module tb_timer_ch0_mode_io_control;
  import tcmio_pkg::*;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic        pclk    = 1'b0;
  logic        presetn = 1'b0;
  logic        ce      = 1'b1;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [19:0] paddr   = 20'h0;
  logic [31:0] pwdata  = 32'h0;
  logic [3:0]  pstrb   = 4'hF;
  logic [15:0] cnt     = 16'h0;
  logic [3:0]  ext     = 4'h0;
  logic [31:0] prdata, rd, v;
  logic        pready, pslverr, er, buf_ac, buf_bd;
  logic [3:0]  pin_i, pin_o, pin_oe, cap_evt, match_evt, caps, mats;
  logic [15:0] g, k;
  tcmio_mode_t mode_sel;
  int          bad_count   = 0;
  int          comparisons = 0;
  // ---------------------------------------------------------------
  // design and far side
  // ---------------------------------------------------------------
  tcmio_top dut_u (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .channel_counter(cnt), .ch0_pin_i(pin_i), .ch0_pin_o(pin_o),
    .ch0_pin_oe(pin_oe), .cap_evt(cap_evt), .match_evt(match_evt),
    .mode_sel(mode_sel), .buffer_pair_ac_select(buf_ac),
    .buffer_pair_bd_select(buf_bd)
  );
  tcmio_pin_model pin_u (
    .pin_o(pin_o), .pin_oe(pin_oe), .ext_drv(ext), .pin_i(pin_i)
  );
  initial begin
    forever #20 pclk = ~pclk;
  end
  // ---------------------------------------------------------------
  // tasks and expectations
  // ---------------------------------------------------------------
  task automatic check(input string n, input logic [31:0] e,
                       input logic [31:0] s);
    comparisons++;
    if (s !== e) begin
      bad_count++;
      $display("wrong value %s: expected %h, seen %h", n, e, s);
    end
  endtask : check
  task automatic chk1(input string n, input logic e, input logic s);
    check(n, {31'h0, e}, {31'h0, s});
  endtask : chk1
  task automatic apb(input logic w, input logic [19:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // collects event pulses over an eight-cycle window
  task automatic watch();
    caps = 4'h0;
    mats = 4'h0;
    repeat (8) begin
      @(posedge pclk);
      caps = caps | cap_evt;
      mats = mats | match_evt;
    end
  endtask : watch
  task automatic give_verdict();
    if (bad_count == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict
  function automatic tcmio_mode_t exp_mode(input logic [3:0] m);
    case (m)
      MC_NORMAL: return MD_NORMAL;
      MC_PWM1:   return MD_PWM1;
      MC_PWM2:   return MD_PWM2;
      default:   return MD_NONE;
    endcase
  endfunction : exp_mode
  function automatic logic exp_lvl(input logic [3:0] c);
    case (c[1:0])
      OC_LOW:  return 1'b0;
      OC_HIGH: return 1'b1;
      default: return ~c[CB_INIT];
    endcase
  endfunction : exp_lvl
  function automatic logic exp_cap(input logic [3:0] c, input logic rise);
    if (c[CB_INIT]) return 1'b0;
    if (c[1]) return 1'b1;
    return c[0] ? ~rise : rise;
  endfunction : exp_cap
  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    #2000000;
    bad_count++;
    $display("wrong value watchdog: expected done, seen timeout");
    give_verdict();
  end
  initial begin
    void'($urandom(32'hFF08A0A8));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, IOH_ADDR, 32'h0);
    check("io_high_rst", 32'h0, rd);
    apb(1'b0, IOL_ADDR, 32'h0);
    check("io_low_rst", 32'h0, rd);
    apb(1'b0, MODE_ADDR, 32'h0);
    check("mode_rst", 32'hC0, rd);
    check("mode_sel_rst", 32'(MD_NORMAL), 32'(mode_sel));
    apb(1'b0, 20'h00010, 32'h0);
    chk1("unmapped_err", 1'b1, er);
    repeat (4) begin
      v = $urandom;
      apb(1'b1, IOH_ADDR, v);
      apb(1'b0, IOH_ADDR, 32'h0);
      check("io_high", {24'h0, v[7:0]}, rd);
      apb(1'b1, IOL_ADDR, v >> 8);
      apb(1'b0, IOL_ADDR, 32'h0);
      check("io_low", {24'h0, v[15:8]}, rd);
    end
    for (int m = 0; m < 16; m++) begin
      if (m == 1) continue;
      v = $urandom;
      apb(1'b1, MODE_ADDR, {26'h0, v[1:0], 4'(m)});
      repeat (2) @(posedge pclk);
      check("mode_sel", 32'(exp_mode(4'(m))), 32'(mode_sel));
      chk1("buffer_ac", v[0], buf_ac);
      chk1("buffer_bd", v[1], buf_bd);
    end
    apb(1'b1, MODE_ADDR, 32'h0);
    for (int c = 0; c < 8; c++) begin
      g = 16'($urandom_range(16'hFF00, 16'h0100));
      cnt <= g - 16'h5;
      apb(1'b1, GR_BASE, {16'h0, g});
      apb(1'b1, IOH_ADDR, {28'h0, 4'(c)});
      watch();
      chk1("oe_a", c[1:0] != 0, pin_oe[0]);
      if (c[1:0] != 0) chk1("init_a", c[2], pin_o[0]);
      cnt <= g;
      watch();
      chk1("match_a", 1'b1, mats[0]);
      if (c[1:0] != 0) chk1("lvl_a", exp_lvl(4'(c)), pin_o[0]);
    end
    for (int c = 8; c < 16; c++) begin
      apb(1'b1, IOH_ADDR, {24'h0, 4'(c), 4'(c)});
      watch();
      for (int e = 0; e < 2; e++) begin
        k = 16'($urandom);
        cnt <= k;
        ext[1:0] <= {2{e == 0}};
        watch();
        chk1("cap_a", exp_cap(4'(c), e == 0), caps[0]);
        chk1("cap_b", exp_cap(4'(c), e == 0), caps[1]);
        if (caps[0]) begin
          apb(1'b0, GR_BASE, 32'h0);
          check("gr_a", {16'h0, k}, rd);
        end
      end
    end
    for (int i = 0; i < 2; i++) begin
      g = 16'($urandom);
      k = 16'($urandom);
      apb(1'b1, MODE_ADDR, (i == 1) ? 32'h20 : 32'h10);
      apb(1'b1, IOH_ADDR, 32'h88);
      apb(1'b1, IOL_ADDR, 32'h88);
      apb(1'b1, GR_BASE + 20'(4 * i), {16'h0, g});
      cnt <= k;
      ext <= 4'h5 << i;
      watch();
      chk1("cap_ab", 1'b1, caps[i]);
      chk1("cap_cd", 1'b0, caps[i+2]);
      apb(1'b0, GR_BASE + 20'(4 * i), 32'h0);
      check("gr_ab", {16'h0, k}, rd);
      apb(1'b0, GR_BASE + 20'(8 + 4 * i), 32'h0);
      check("gr_cd", {16'h0, g}, rd);
      ext <= 4'h0;
      watch();
    end
    // paired compare on B reloads it from D, then a frozen clock
    g = 16'($urandom);
    k = ~g;
    cnt <= g ^ 16'h0001;
    apb(1'b1, IOH_ADDR, 32'h30);
    apb(1'b1, GR_BASE + 20'hC, {16'h0, k});
    apb(1'b1, GR_BASE + 20'h4, {16'h0, g});
    cnt <= g;
    watch();
    chk1("match_b", 1'b1, mats[1]);
    chk1("match_d", 1'b0, mats[3]);
    chk1("tgl_b", 1'b1, pin_o[1]);
    apb(1'b0, GR_BASE + 20'h4, 32'h0);
    check("gr_b_reload", {16'h0, k}, rd);
    ce <= 1'b0;
    cnt <= k;
    watch();
    chk1("frozen_b", 1'b0, mats[1]);
    ce <= 1'b1;
    watch();
    chk1("thawed_b", 1'b1, mats[1]);
    give_verdict();
  end
endmodule : tb_timer_ch0_mode_io_control
